// ---- field_cmd_pkg.sv ----
// constants and state types of the configuration field command handler
package field_cmd_pkg;
	localparam logic [7:0] SYNC_BYTE = 8'h55;
	localparam logic [15:0] NONVOLATILE_STORE_CMD = 16'h5746;
	localparam logic [15:0] LIVE_APPLY_CMD = 16'h5346;
	localparam logic [15:0] NAK_TYPE = 16'h1515;
	localparam logic [15:0] CRC_INIT = 16'h1D0F;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [2:0] MAX_ENTRIES = 3'h4;
	localparam logic [3:0] FIELD_COUNT = 4'hC;
	// field identifiers
	localparam logic [15:0] FID_RATE_DIV = 16'h0001;
	localparam logic [15:0] FID_BAUD = 16'h0002;
	localparam logic [15:0] FID_FILTER1 = 16'h0004;
	localparam logic [15:0] FID_FILTER3 = 16'h0006;
	localparam logic [15:0] FID_ORIENT = 16'h0007;
	localparam logic [15:0] FID_HEADING_OFFSET = 16'h000C;
	// valid value bounds and live reset value
	localparam logic [15:0] BAUD_MAX = 16'h0003;
	localparam logic [15:0] FILTER_MIN = 16'h053A;
	localparam logic [15:0] FILTER_MAX = 16'h68A1;
	localparam logic [15:0] LIVE_RESET = 16'h0000;
	// response and command byte layout
	localparam logic [8:0] OK_FIXED_BYTES = 9'h008;
	localparam logic [8:0] ERR_TOTAL_BYTES = 9'h009;
	localparam logic [8:0] PAYLOAD_START = 9'h003;
	typedef enum logic [4:0] {
		ST_HUNT = 5'b00001,
		ST_RECV = 5'b00010,
		ST_APPLY = 5'b00100,
		ST_TXOK = 5'b01000,
		ST_TXERR = 5'b10000
	} state_t;
endpackage : field_cmd_pkg

// ---- config_field_write_set_handler.sv ----
// packet parser and executor for store and apply configuration commands
`timescale 1ns/10ps

// What this block does
// - A store command is sync, sync, type 0x5746, length 1+4n, payload, crc.
// - Store command values go only to the power-up defaults, never live.
// - Store payload is a count byte then id/value word pairs from byte 1.
// - Store entries aimed at calibration or algorithm fields fail.
// - If any store entry succeeds, a response lists only the stored ids.
// - Any failed store entry yields an error packet, maybe after success.
// - A value outside its field's valid set fails and is not stored.
// - Store success reply: sync, sync, 0x5746, length 1+2n, count, ids, crc.
// - An apply command is sync, sync, type 0x5346, length 1+4n, payload, crc.
// - Apply command values change the live volatile fields at once.
// - Apply payload is a count byte then id/value word pairs from byte 1.
// - Apply entries aimed at calibration or algorithm fields fail.
// - If any apply entry succeeds, a response lists the applied ids.
// - Any failed apply entry, bad values included, yields an error packet.
// - Field 0x000C holds the signed heading-to-track angle offset.
// - A new baud selection takes effect before the reply is sent.
module config_field_write_set_handler (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_valid_i,
	input wire logic tx_ready_i,
	output logic [7:0] tx_byte_o,
	output logic tx_valid_o,
	output logic nv_wr_o,
	output logic [15:0] nv_id_o,
	output logic [15:0] nv_value_o,
	output logic [191:0] live_cfg_o,
	output logic [15:0] heading_to_track_offset_o,
	output logic [1:0] baud_sel_o
);
	typedef struct packed {
		field_cmd_pkg::state_t state;
		logic pre;
		logic [8:0] pos;
		logic [15:0] typ;
		logic [7:0] len;
		logic [7:0] entry_count;
		logic [15:0] crc;
		logic [7:0] rcrc_hi;
		logic [3:0][15:0] ent_id;
		logic [3:0][15:0] ent_val;
		logic [2:0] idx;
		logic [2:0] nok;
		logic fail;
		logic [3:0][15:0] rid;
		logic [11:0][15:0] live;
		logic nv_wr;
		logic [15:0] nv_id;
		logic [15:0] nv_val;
		logic [8:0] tpos;
		logic [7:0] tx_byte;
		logic tx_valid;
		logic [15:0] tcrc;
	} state_s_t;

	state_s_t s_q, s_d;
	logic [8:0] pay_end, tot, k, j;
	logic [15:0] cur_id, cur_val, ok_type;
	logic ent_ok, is_live, len_good, slot_free;
	logic [7:0] tb, pick;

	function automatic logic [15:0] crc_upd(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ field_cmd_pkg::CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : crc_upd

	function automatic logic [1:0] next3(input logic [1:0] a);
		return (a == 2'h2) ? 2'h0 : 2'(a + 2'h1);
	endfunction : next3

	// orientation: three distinct physical axes, right handed overall
	function automatic logic orient_ok(input logic [15:0] v);
		logic [1:0] px, py, pz;
		logic odd;
		px = v[2:1];
		py = next3(v[5:4]);
		pz = next3(next3(v[8:7]));
		odd = (py != next3(px));
		return (v[15:9] == 7'h00) && (v[2:1] != 2'h3) && (v[5:4] != 2'h3)
			&& (v[8:7] != 2'h3) && (px != py) && (py != pz) && (px != pz)
			&& ((v[0] ^ v[3] ^ v[6]) == odd);
	endfunction : orient_ok

	// only ids 1..12 are configuration fields; all else is refused
	function automatic logic value_ok(input logic [15:0] id,
		input logic [15:0] v);
		if (id == 16'h0000 || id > 16'(field_cmd_pkg::FIELD_COUNT))
			return 1'b0;
		if (id == field_cmd_pkg::FID_RATE_DIV)
			return v inside {16'h0000, 16'h0001, 16'h0002, 16'h0005,
				16'h000A, 16'h0014, 16'h0019, 16'h0032};
		if (id == field_cmd_pkg::FID_BAUD)
			return v <= field_cmd_pkg::BAUD_MAX;
		if (id >= field_cmd_pkg::FID_FILTER1 &&
			id <= field_cmd_pkg::FID_FILTER3)
			return v >= field_cmd_pkg::FILTER_MIN &&
				v <= field_cmd_pkg::FILTER_MAX;
		if (id == field_cmd_pkg::FID_ORIENT)
			return orient_ok(v);
		return 1'b1;
	endfunction : value_ok

	////////////////////////////////////////////////////////////////////////
	// helper terms for parsing and reply building
	assign pay_end = 9'(s_q.len) + field_cmd_pkg::PAYLOAD_START;
	assign k = s_q.pos - 9'h004;
	assign cur_id = s_q.ent_id[s_q.idx[1:0]];
	assign cur_val = s_q.ent_val[s_q.idx[1:0]];
	assign ent_ok = value_ok(cur_id, cur_val);
	assign is_live = (s_q.typ == field_cmd_pkg::LIVE_APPLY_CMD);
	assign len_good = (10'(s_q.len) == 10'({s_q.entry_count, 2'b00}) + 10'h001)
		&& (s_q.entry_count <= 8'(field_cmd_pkg::MAX_ENTRIES));
	assign tot = (s_q.state == field_cmd_pkg::ST_TXOK) ?
		field_cmd_pkg::OK_FIXED_BYTES + 9'({s_q.nok, 1'b0}) :
		field_cmd_pkg::ERR_TOTAL_BYTES;
	assign j = s_q.tpos - 9'h006;
	assign ok_type = (s_q.state == field_cmd_pkg::ST_TXOK) ? s_q.typ :
		field_cmd_pkg::NAK_TYPE;
	assign slot_free = !s_q.tx_valid || tx_ready_i;

	// byte of the reply at tpos; crc trailer overrides the body
	always_comb begin
		pick = 8'h00;
		case (s_q.tpos)
			9'h000, 9'h001: pick = field_cmd_pkg::SYNC_BYTE;
			9'h002: pick = ok_type[15:8];
			9'h003: pick = ok_type[7:0];
			9'h004: pick = (s_q.state == field_cmd_pkg::ST_TXOK) ?
				8'h01 + {4'h0, s_q.nok, 1'b0} : 8'h02;
			9'h005: pick = (s_q.state == field_cmd_pkg::ST_TXOK) ?
				{5'h00, s_q.nok} : s_q.typ[15:8];
			default: begin
				if (s_q.state == field_cmd_pkg::ST_TXOK)
					pick = j[0] ? s_q.rid[j[2:1]][7:0] : s_q.rid[j[2:1]][15:8];
				else
					pick = s_q.typ[7:0];
			end
		endcase
		if (s_q.tpos == tot - 9'h002)
			tb = s_q.tcrc[15:8];
		else if (s_q.tpos == tot - 9'h001)
			tb = s_q.tcrc[7:0];
		else
			tb = pick;
	end

	////////////////////////////////////////////////////////////////////////
	// next state of the whole handler
	always_comb begin
		s_d = s_q;
		s_d.nv_wr = 1'b0;
		case (s_q.state)
			field_cmd_pkg::ST_HUNT: begin
				if (rx_valid_i) begin
					s_d.pre = (rx_byte_i == field_cmd_pkg::SYNC_BYTE);
					if (s_q.pre && rx_byte_i == field_cmd_pkg::SYNC_BYTE) begin
						s_d.state = field_cmd_pkg::ST_RECV;
						s_d.pos = 9'h000;
						s_d.crc = field_cmd_pkg::CRC_INIT;
						s_d.pre = 1'b0;
					end
				end
			end
			field_cmd_pkg::ST_RECV: begin
				if (rx_valid_i) begin
					s_d.pos = s_q.pos + 9'h001;
					if (s_q.pos < pay_end)
						s_d.crc = crc_upd(s_q.crc, rx_byte_i);
					if (s_q.pos == pay_end) begin
						s_d.rcrc_hi = rx_byte_i;
					end else if (s_q.pos == pay_end + 9'h001) begin
						// bad crc or length: drop silently, nothing applied
						if ({s_q.rcrc_hi, rx_byte_i} == s_q.crc && len_good) begin
							s_d.state = field_cmd_pkg::ST_APPLY;
						end else begin
							s_d.state = field_cmd_pkg::ST_HUNT;
						end
						s_d.idx = 3'h0;
						s_d.nok = 3'h0;
						s_d.fail = 1'b0;
					end else if (s_q.pos == 9'h000) begin
						s_d.typ[15:8] = rx_byte_i;
					end else if (s_q.pos == 9'h001) begin
						s_d.typ[7:0] = rx_byte_i;
						// other packet types belong to other handlers
						if ({s_q.typ[15:8], rx_byte_i} !=
							field_cmd_pkg::NONVOLATILE_STORE_CMD &&
							{s_q.typ[15:8], rx_byte_i} !=
							field_cmd_pkg::LIVE_APPLY_CMD)
							s_d.state = field_cmd_pkg::ST_HUNT;
					end else if (s_q.pos == 9'h002) begin
						s_d.len = rx_byte_i;
					end else if (s_q.pos == 9'h003) begin
						s_d.entry_count = rx_byte_i;
					end else if (k < 9'h010) begin
						// id high, id low, value high, value low
						case (k[1:0])
							2'h0: s_d.ent_id[k[3:2]][15:8] = rx_byte_i;
							2'h1: s_d.ent_id[k[3:2]][7:0] = rx_byte_i;
							2'h2: s_d.ent_val[k[3:2]][15:8] = rx_byte_i;
							default: s_d.ent_val[k[3:2]][7:0] = rx_byte_i;
						endcase
					end
				end
			end
			field_cmd_pkg::ST_APPLY: begin
				if (s_q.idx == s_q.entry_count[2:0]) begin
					s_d.tpos = 9'h000;
					s_d.tcrc = field_cmd_pkg::CRC_INIT;
					s_d.tx_valid = 1'b0;
					if (s_q.nok != 3'h0)
						s_d.state = field_cmd_pkg::ST_TXOK;
					else if (s_q.fail)
						s_d.state = field_cmd_pkg::ST_TXERR;
					else
						s_d.state = field_cmd_pkg::ST_HUNT;
				end else begin
					s_d.idx = s_q.idx + 3'h1;
					if (ent_ok) begin
						s_d.rid[s_q.nok[1:0]] = cur_id;
						s_d.nok = s_q.nok + 3'h1;
						if (is_live) begin
							// baud moves now, so the reply leaves at the new rate
							s_d.live[4'(cur_id[3:0] - 4'h1)] = cur_val;
						end else begin
							s_d.nv_wr = 1'b1;
							s_d.nv_id = cur_id;
							s_d.nv_val = cur_val;
						end
					end else begin
						s_d.fail = 1'b1;
					end
				end
			end
			field_cmd_pkg::ST_TXOK, field_cmd_pkg::ST_TXERR: begin
				if (slot_free) begin
					if (s_q.tpos == tot) begin
						s_d.tx_valid = 1'b0;
						s_d.tpos = 9'h000;
						s_d.tcrc = field_cmd_pkg::CRC_INIT;
						s_d.state = (s_q.state == field_cmd_pkg::ST_TXOK &&
							s_q.fail) ? field_cmd_pkg::ST_TXERR :
							field_cmd_pkg::ST_HUNT;
					end else begin
						s_d.tx_valid = 1'b1;
						s_d.tx_byte = tb;
						s_d.tpos = s_q.tpos + 9'h001;
						if (s_q.tpos >= 9'h002 && s_q.tpos < tot - 9'h002)
							s_d.tcrc = crc_upd(s_q.tcrc, tb);
					end
				end
			end
			default: s_d.state = field_cmd_pkg::ST_HUNT;
		endcase
	end

	// state register; live fields come up at their volatile defaults
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '0;
			s_q.state <= field_cmd_pkg::ST_HUNT;
			s_q.live <= {12{field_cmd_pkg::LIVE_RESET}};
		end else begin
			s_q <= s_d;
		end
	end

	assign tx_byte_o = s_q.tx_byte;
	assign tx_valid_o = s_q.tx_valid;
	assign nv_wr_o = s_q.nv_wr;
	assign nv_id_o = s_q.nv_id;
	assign nv_value_o = s_q.nv_val;
	assign live_cfg_o = s_q.live;
	assign heading_to_track_offset_o = s_q.live[11];
	assign baud_sel_o = s_q.live[1][1:0];

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_store_step;
		s_q.state == field_cmd_pkg::ST_APPLY && !is_live &&
			s_q.idx != s_q.entry_count[2:0];
	endsequence
	sequence s_apply_step;
		s_q.state == field_cmd_pkg::ST_APPLY && is_live &&
			s_q.idx != s_q.entry_count[2:0] && ent_ok;
	endsequence

	property p_store_not_live;
		s_store_step |=> $stable(live_cfg_o);
	endproperty
	a_store_not_live: assert property (p_store_not_live)
		else $error("store command changed live fields");
	property p_store_id_ok;
		nv_wr_o |-> nv_id_o != 16'h0000 && nv_id_o <= 16'h000C;
	endproperty
	a_store_id_ok: assert property (p_store_id_ok)
		else $error("store of non-configuration field");
	property p_bad_value;
		s_store_step ##0 !ent_ok |=> !nv_wr_o && s_q.fail;
	endproperty
	a_bad_value: assert property (p_bad_value)
		else $error("invalid value was stored");
	property p_heading_apply;
		s_apply_step ##0 cur_id == field_cmd_pkg::FID_HEADING_OFFSET
			|=> heading_to_track_offset_o == $past(cur_val);
	endproperty
	a_heading_apply: assert property (p_heading_apply)
		else $error("heading offset not applied");
	property p_ok_reply;
		s_q.state == field_cmd_pkg::ST_TXOK &&
			$past(s_q.state) == field_cmd_pkg::ST_APPLY |-> s_q.nok != 3'h0;
	endproperty
	a_ok_reply: assert property (p_ok_reply)
		else $error("success reply with nothing done");
	property p_err_reply;
		$rose(s_q.state == field_cmd_pkg::ST_TXERR) |-> s_q.fail;
	endproperty
	a_err_reply: assert property (p_err_reply)
		else $error("error reply without failure");
	property p_sync_first;
		$rose(tx_valid_o) && s_q.tpos == 9'h001 |->
			tx_byte_o == field_cmd_pkg::SYNC_BYTE ##1
			(tx_byte_o == field_cmd_pkg::SYNC_BYTE || !tx_ready_i);
	endproperty
	a_sync_first: assert property (p_sync_first)
		else $error("reply does not start with sync");
	property p_ok_len;
		tx_valid_o && s_q.state == field_cmd_pkg::ST_TXOK &&
			s_q.tpos == 9'h005 |-> tx_byte_o == 8'h01 + {4'h0, s_q.nok, 1'b0};
	endproperty
	a_ok_len: assert property (p_ok_len)
		else $error("success reply length wrong");
	property p_discard;
		s_q.state == field_cmd_pkg::ST_RECV && rx_valid_i &&
			s_q.pos == pay_end + 9'h001 && !len_good
			|=> s_q.state == field_cmd_pkg::ST_HUNT ##1 $stable(live_cfg_o);
	endproperty
	a_discard: assert property (p_discard)
		else $error("bad packet was not discarded");
	property p_baud_steady;
		s_q.state == field_cmd_pkg::ST_TXOK |=> $stable(baud_sel_o);
	endproperty
	a_baud_steady: assert property (p_baud_steady)
		else $error("baud moved during reply");
endmodule : config_field_write_set_handler

// ---- field_host_model.sv ----
// host model that drives command bytes and gathers reply bytes
`timescale 1ns/10ps
module field_host_model (
	input wire logic mclk_i,
	output logic [7:0] rx_byte_o,
	output logic rx_valid_o,
	output logic tx_ready_o,
	input wire logic [7:0] tx_byte_i,
	input wire logic tx_valid_i
);
	logic [7:0] got[$];
	bit slow = 0;
	int tick = 0;
	initial begin
		rx_byte_o = 8'h00;
		rx_valid_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// one byte per valid cycle; idle data is inverted so a parser that
	// samples without valid picks up junk rather than a stale byte
	task automatic send(input logic [7:0] pkt[$]);
		foreach (pkt[i]) begin
			@(negedge mclk_i);
			rx_byte_o = pkt[i];
			rx_valid_o = 1'b1;
			if (slow) begin
				@(negedge mclk_i);
				rx_valid_o = 1'b0;
				rx_byte_o = ~pkt[i];
			end
		end
		@(negedge mclk_i);
		rx_valid_o = 1'b0;
		rx_byte_o = ~rx_byte_o;
	endtask : send
	// slow mode stalls the transmitter two cycles in three
	always @(negedge mclk_i) begin
		tick <= tick + 1;
		tx_ready_o <= !slow || (tick % 3 == 0);
	end
	// both the success and the error packet are kept for one command
	always @(posedge mclk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			got.push_back(tx_byte_i);
		end
	end
endmodule : field_host_model

// ---- tb_config_field_write_set_handler.sv ----
// self-checking bench of the configuration field command handler
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
	$display("[FAIL] %0t value mismatch", $time); end end
module tb_config_field_write_set_handler;
	logic mclk_i, resetn_i, rx_valid, tx_ready, tx_valid, nv_wr;
	logic [7:0] rx_byte, tx_byte;
	logic [15:0] nv_id, nv_value, hto;
	logic [191:0] live_cfg;
	logic [1:0] baud_sel;
	logic [7:0] exp[$];
	logic [31:0] nvx[$], nv_got[$];
	logic [15:0] live[1:12];
	logic [15:0] rnd = 16'hFAE0;
	int n_fail = 0, checked = 0, cycles = 0;
	config_field_write_set_handler u_config_field_write_set_handler (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .rx_byte_i(rx_byte),
		.rx_valid_i(rx_valid), .tx_ready_i(tx_ready), .tx_byte_o(tx_byte),
		.tx_valid_o(tx_valid), .nv_wr_o(nv_wr), .nv_id_o(nv_id),
		.nv_value_o(nv_value), .live_cfg_o(live_cfg),
		.heading_to_track_offset_o(hto), .baud_sel_o(baud_sel));
	field_host_model u_field_host_model (.mclk_i(mclk_i),
		.rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .tx_ready_o(tx_ready),
		.tx_byte_i(tx_byte), .tx_valid_i(tx_valid));
	////////////////////////////////////////////////////////////////////////
	// clock at 25 ns; the timeout counts cycles and closes the run
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cycles++;
		if (nv_wr === 1'b1) nv_got.push_back({nv_id, nv_value});
		if (cycles == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	// the verdict is printed here only
	task automatic end_of_test;
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// crc over type, length and payload, msb first
	function automatic logic [15:0] crc(input logic [7:0] d[$]);
		logic [15:0] c;
		c = 16'h1D0F;
		foreach (d[i]) begin
			c ^= {d[i], 8'h00};
			for (int k = 0; k < 8; k++) c = c[15] ? (c << 1) ^ 16'h1021 : c << 1;
		end
		return c;
	endfunction : crc
	function automatic void put(ref logic [7:0] q[$], input logic [15:0] w);
		q.push_back(w[15:8]);
		q.push_back(w[7:0]);
	endfunction : put
	function automatic void frame(input logic [7:0] b[$]);
		exp = {exp, 8'h55, 8'h55, b};
		put(exp, crc(b));
	endfunction : frame
	// accepted values of each configuration field; others are refused
	function automatic bit ok_val(input int id, input int v);
		int ori[24] = '{0, 9, 35, 42, 65, 72, 98, 107, 133, 140, 146, 155,
			196, 205, 211, 218, 273, 280, 292, 301, 336, 345, 357, 364};
		case (id)
			1: return v inside {0, 1, 2, 5, 10, 20, 25, 50};
			2: return v <= 3;
			4, 5, 6: return v >= 1338 && v <= 26785;
			7: return v inside {ori};
			3, 8, 9, 10, 11, 12: return 1;
			default: return 0;
		endcase
	endfunction : ok_val
	////////////////////////////////////////////////////////////////////////
	// send one command, run the model, compare reply, stores and live set;
	// bad 1 spoils the crc, bad 2 spoils the length
	task automatic run_cmd(input logic [15:0] typ, input int n,
		input logic [15:0] ids[4], input logic [15:0] vals[4], input int bad);
		logic [7:0] p[$], r[$], x[$];
		logic [15:0] ok[$];
		bit fail;
		fail = 0;
		exp.delete();
		nvx.delete();
		p = {typ[15:8], typ[7:0], 8'(1 + 4 * n + (bad == 2 ? 4 : 0)), 8'(n)};
		for (int i = 0; i < n; i++) begin
			put(p, ids[i]);
			put(p, vals[i]);
			if (bad == 0 && ok_val(ids[i], vals[i])) begin
				ok.push_back(ids[i]);
				if (typ == 16'h5746) nvx.push_back({ids[i], vals[i]});
				else live[ids[i]] = vals[i];
			end else if (bad == 0) fail = 1;
		end
		// the length counts one entry more than the count byte gives; the pad
		// keeps the crc where the length puts it, so only the length is wrong
		if (bad == 2) begin
			put(p, 16'h0001);
			put(p, 16'h0005);
		end
		x = {8'h55, 8'h55, p};
		put(x, crc(p) ^ 16'(bad == 1));
		if (ok.size() > 0) begin
			r = {typ[15:8], typ[7:0], 8'(1 + 2 * ok.size()), 8'(ok.size())};
			foreach (ok[i]) put(r, ok[i]);
			frame(r);
		end
		if (fail) frame({8'h15, 8'h15, 8'h02, typ[15:8], typ[7:0]});
		u_field_host_model.got.delete();
		nv_got.delete();
		u_field_host_model.send(x);
		for (int i = 0; i < 2000 && u_field_host_model.got.size() < exp.size();
			i++) @(posedge mclk_i);
		repeat (20) @(posedge mclk_i);
		`CHK(u_field_host_model.got.size(), exp.size())
		foreach (exp[i]) `CHK(u_field_host_model.got[i], exp[i])
		`CHK(nv_got.size(), nvx.size())
		foreach (nvx[i]) `CHK(nv_got[i], nvx[i])
		for (int i = 1; i <= 12; i++) `CHK(live_cfg[16*i-1 -: 16], live[i])
		`CHK(hto, live[12])
		`CHK(baud_sel, live[2][1:0])
	endtask : run_cmd
	// main sequence
	initial begin
		resetn_i = 1'b0;
		foreach (live[i]) live[i] = 16'h0000;
		repeat (2) @(negedge mclk_i);
		resetn_i = 1'b1;
		run_cmd(16'h5746, 1, '{16'h0002, 0, 0, 0}, '{16'h0001, 0, 0, 0}, 0);
		rnd = lfsr(rnd);
		u_field_host_model.slow = 1;
		// store with refused id, bad value and good entries
		run_cmd(16'h5746, 4, '{16'h000C, 16'h000D, 16'h0001, 16'h0008},
			'{rnd, 16'h0005, 16'h0003, ~rnd}, 0);
		// apply with bad orientation and a filter low bound
		run_cmd(16'h5346, 4, '{16'h0002, 16'h000C, 16'h0007, 16'h0004},
			'{16'h0003, rnd, 16'h0001, 16'h053A}, 0);
		u_field_host_model.slow = 0;
		// apply where every entry fails
		run_cmd(16'h5346, 3, '{16'h0004, 16'h0000, 16'h000D, 0},
			'{16'h68A2, 16'h0000, 16'h0005, 0}, 0);
		run_cmd(16'h5346, 1, '{16'h0002, 0, 0, 0}, '{16'h0000, 0, 0, 0}, 1);
		run_cmd(16'h5346, 1, '{16'h0001, 0, 0, 0}, '{16'h0005, 0, 0, 0}, 2);
		// random rates and orientations, the model decides validity
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			run_cmd(k[0] ? 16'h5746 : 16'h5346, 2, '{16'h0001, 16'h0007, 0, 0},
				'{16'(rnd[5:0]), 16'(rnd[15:7]), 0, 0}, 0);
		end
		end_of_test();
	end
endmodule : tb_config_field_write_set_handler
